// *** bench/cld_decoder_tb.sv ***
// self-checking bench for the control and literal decoder
`timescale 1ns/100ps
module cld_decoder_tb;
    import cld_pkg::*;
    logic ref_clk, rst_n, load, word_valid, word_ready, test_bit, kill;
    logic reg_wr, reg_rd;
    logic [15:0] next_word, word, w;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [16:0] first;
    cld_flags_t flags;
    cld_dec_t dec, e;
    int n_errors, checks_done, i;
    localparam logic [15:0] BASE [12] = '{16'h9000, 16'h8000, 16'h7000,
        16'hb000, 16'ha000, 16'hd000, 16'he000, 16'hec00, 16'hf000,
        16'h0800, 16'h0000, 16'h0100};
    localparam logic [15:0] MASK [12] = '{16'hfff, 16'hfff, 16'hfff,
        16'hfff, 16'hfff, 16'hfff, 16'h7ff, 16'h33f, 16'hfff, 16'h7ff,
        16'h1f, 16'hf};
    cld_prog_mem mem (.ref_clk(ref_clk), .load(load), .next_word(next_word),
        .word_ready(word_ready), .word_valid(word_valid), .word(word));
    cld_decoder dut (.ref_clk(ref_clk), .rst_n(rst_n), .word(word),
        .word_valid(word_valid), .word_ready(word_ready), .flags(flags),
        .test_bit(test_bit), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dec(dec));
    task automatic chk(string n, logic [19:0] x, logic [19:0] g);
        checks_done++;
        if (g !== x) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    // expected decode; kill and first carry the discard and pairing state
    function automatic void model(logic [15:0] v);
        logic c;
        e = '0;
        e.valid = 1'b1;
        e.cycles = CYC_ONE;
        c = v[10] ? (v[9] ? flags.neg : flags.overflow)
                  : (v[9] ? flags.carry : flags.zero);
        e.konst = v[7:0];
        e.tbl_mode = v[1:0];
        e.abs_addr = {v[11:0], first[7:0]};
        e.ptr_val = {first[3:0], v[7:0]};
        if (kill) e.op = OP_NOP;
        else if (first[16]) begin
            e.op = !first[9] ? OP_ABS_CALL : first[8] ? OP_ABS_JUMP
                 : OP_PTR_LOAD;
            e.cycles = CYC_TWO;
        end else case (v[15:12])
            NIB_BCLR: e.op = OP_BIT_CLEAR;
            NIB_BSET: e.op = OP_BIT_SET;
            NIB_BTGL: e.op = OP_BIT_TOGGLE;
            NIB_TCLR: e.op = OP_TEST_SKIP_CLEAR;
            NIB_TSET: e.op = OP_TEST_SKIP_SET;
            NIB_REL: e.op = v[11] ? OP_REL_CALL : OP_REL_JUMP;
            NIB_LONG: e.op = v[11] ? OP_NOP : OP_COND_JUMP;
            NIB_MISC: case (v[11:8])
                LIT_ADD: e.op = OP_ADD_CONST;
                LIT_SUB: e.op = OP_CONST_MINUS;
                LIT_AND: e.op = OP_AND_CONST;
                LIT_OR: e.op = OP_OR_CONST;
                LIT_XOR: e.op = OP_XOR_CONST;
                LIT_MUL: e.op = OP_MUL_CONST;
                LIT_LOAD: e.op = OP_LOAD_CONST;
                LIT_RET: e.op = OP_RETURN_CONST;
                LIT_BANK: e.op = OP_BANK_LOAD;
                default: case (v[7:0])
                    CW_NOP: e.op = OP_NOP;
                    CW_SLEEP: e.op = OP_STANDBY;
                    CW_WDT: e.op = OP_WDT_CLEAR;
                    CW_PUSH: e.op = OP_STACK_PUSH;
                    CW_POP: e.op = OP_STACK_POP;
                    CW_DAW: e.op = OP_DEC_ADJUST;
                    CW_RESET: e.op = OP_SOFT_RESET;
                    8'h08, 8'h09, 8'h0a, 8'h0b: e.op = OP_TABLE_READ;
                    8'h0c, 8'h0d, 8'h0e, 8'h0f: e.op = OP_TABLE_WRITE;
                    8'h10, 8'h11: e.op = OP_IRQ_RETURN;
                    8'h12, 8'h13: e.op = OP_SUB_RETURN;
                    default: e.op = OP_OTHER;
                endcase
            endcase
            default: e.op = OP_NOP;
        endcase
        if (!kill && !first[16] && v[15:10] == 6'h3b) e.valid = 1'b0;
        if (e.op inside {OP_REL_CALL, OP_REL_JUMP, OP_RETURN_CONST,
            OP_TABLE_READ, OP_TABLE_WRITE, OP_IRQ_RETURN, OP_SUB_RETURN}
            || (e.op == OP_COND_JUMP && (c ^ v[8]))) e.cycles = CYC_TWO;
        e.pc_change = e.cycles == CYC_TWO && !(e.op inside
            {OP_TABLE_READ, OP_TABLE_WRITE, OP_PTR_LOAD});
        e.flags_upd = e.op inside {OP_ADD_CONST, OP_CONST_MINUS} ? 5'h1f
            : e.op inside {OP_AND_CONST, OP_OR_CONST, OP_XOR_CONST} ? 5'h14
            : e.op == OP_DEC_ADJUST ? 5'h01 : 5'h00;
    endfunction : model
    // present a word, wait for its take, then judge the decode
    task automatic issue(logic [15:0] v);
        @(posedge ref_clk);
        load <= 1'b1;
        next_word <= v;
        @(posedge ref_clk);
        load <= 1'b0;
        @(posedge ref_clk);
        model(v);
        #1 chk("valid", e.valid, dec.valid);
        if (e.valid) chk("op", e.op, dec.op);
        if (e.valid) chk("cycles", e.cycles, dec.cycles);
        if (e.valid) chk("flags", e.flags_upd, dec.flags_upd);
        if (!(e.op inside {OP_TEST_SKIP_SET, OP_TEST_SKIP_CLEAR}))
            chk("pc", e.pc_change, dec.pc_change);
        if (e.op inside {OP_ABS_CALL, OP_ABS_JUMP})
            chk("abs", e.abs_addr, dec.abs_addr);
        if (e.op == OP_PTR_LOAD) chk("ptr", e.ptr_val, dec.ptr_val);
        if (v[15:11] == 5'h01 && !kill) chk("k", e.konst, dec.konst);
        if (e.op inside {OP_TABLE_READ, OP_TABLE_WRITE}) begin
            chk("mode", e.tbl_mode, dec.tbl_mode);
            chk("ready", 1'b0, word_ready);
        end
        kill = e.pc_change || (e.op == OP_TEST_SKIP_SET && test_bit)
            || (e.op == OP_TEST_SKIP_CLEAR && !test_bit);
        first = {!e.valid, v};
    endtask : issue
    task automatic reg_op(logic wr, logic [1:0] a, logic [7:0] d);
        @(posedge ref_clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {wr, !wr, a, d};
        @(posedge ref_clk);
        {reg_wr, reg_rd} <= 2'b00;
        #1 if (!wr) chk("rdata", d, reg_rdata);
    endtask : reg_op
    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        #40000 n_errors++;
        complete_run();
    end
    initial begin
        {rst_n, load, reg_wr, reg_rd, test_bit, kill, flags} = '0;
        {next_word, reg_addr, reg_wdata, first} = '0;
        i = $urandom(32'hbb12);
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        reg_op(1'b0, REG_STAT, 8'h03);
        reg_op(1'b1, REG_CTRL, 8'h01);
        reg_op(1'b1, REG_STAT, 8'h00);
        reg_op(1'b0, REG_CTRL, 8'h01);
        issue(16'h94d6);
        chk("presc", 1'b1, dec.presc_clear);
        issue(16'h8080);
        chk("pins", 1'b1, dec.pin_read);
        // random words per group; ends on a bank load so nothing is skipped
        for (i = 0; i < 396; i++) begin
            w = BASE[i % 12] | (MASK[i % 12] & 16'($urandom));
            flags <= cld_flags_t'($urandom);
            test_bit <= 1'($urandom);
            issue(w);
        end
        issue(16'h010a);
        reg_op(1'b0, REG_BANK, 8'h0a);
        issue(16'h00ff);
        chk("swrst", 1'b1, dec.sw_reset);
        reg_op(1'b0, REG_CTRL, 8'h00);
        complete_run();
    end
endmodule : cld_decoder_tb

// *** bench/cld_prog_mem.sv ***
// program memory model handing out one word at a time
`timescale 1ns/100ps
module cld_prog_mem (
    input  wire logic        ref_clk,
    input  wire logic        load,
    input  wire logic [15:0] next_word,
    input  wire logic        word_ready,
    output logic             word_valid,
    output logic [15:0]      word
);
    initial begin
        word_valid = 1'b0;
        word = 16'h0000;
    end
    // word held until taken, then scrambled so stale data never passes
    always @(posedge ref_clk) begin
        if (load) begin
            word_valid <= 1'b1;
            word <= next_word;
        end else if (word_valid && word_ready) begin
            word_valid <= 1'b0;
            word <= ~word;
        end
    end
endmodule : cld_prog_mem

// *** common/cld_pkg.sv ***
// shared types and constants of the control and literal decoder
package cld_pkg;
    // register map of the plain register port
    localparam int         REG_AW      = 2;
    localparam logic [1:0] REG_CTRL    = 2'h0;
    localparam logic [1:0] REG_STAT    = 2'h1;
    localparam logic [1:0] REG_LAST    = 2'h2;
    localparam logic [1:0] REG_BANK    = 2'h3;
    localparam int         CTRL_PRESC  = 0;
    localparam int         STAT_TMOUT  = 0;
    localparam int         STAT_PWRDN  = 1;
    localparam int         STAT_FLUSH  = 2;
    localparam int         STAT_SKIP   = 3;
    localparam int         STAT_SECOND = 4;
    localparam logic [7:0] CTRL_RST    = 8'h00;
    localparam logic       TMOUT_RST   = 1'b1;
    localparam logic       PWRDN_RST   = 1'b1;
    // cycle counts
    localparam logic [1:0] CYC_ONE     = 2'h1;
    localparam logic [1:0] CYC_TWO     = 2'h2;
    // top nibbles and prefixes
    localparam logic [3:0] NIB_MISC    = 4'h0;
    localparam logic [3:0] NIB_BTGL    = 4'h7;
    localparam logic [3:0] NIB_BSET    = 4'h8;
    localparam logic [3:0] NIB_BCLR    = 4'h9;
    localparam logic [3:0] NIB_TSET    = 4'ha;
    localparam logic [3:0] NIB_TCLR    = 4'hb;
    localparam logic [3:0] NIB_REL     = 4'hd;
    localparam logic [3:0] NIB_LONG    = 4'he;
    localparam logic [3:0] NIB_SECOND  = 4'hf;
    localparam logic [2:0] SUB_CALL    = 3'h6;
    localparam logic [3:0] SUB_JUMP    = 4'hf;
    localparam logic [3:0] SUB_PTR     = 4'he;
    localparam logic [1:0] PTR_ZERO    = 2'h0;
    // second nibble of the literal group
    localparam logic [3:0] LIT_CTRL    = 4'h0;
    localparam logic [3:0] LIT_BANK    = 4'h1;
    localparam logic [3:0] LIT_SUB     = 4'h8;
    localparam logic [3:0] LIT_OR      = 4'h9;
    localparam logic [3:0] LIT_XOR     = 4'ha;
    localparam logic [3:0] LIT_AND     = 4'hb;
    localparam logic [3:0] LIT_RET     = 4'hc;
    localparam logic [3:0] LIT_MUL     = 4'hd;
    localparam logic [3:0] LIT_LOAD    = 4'he;
    localparam logic [3:0] LIT_ADD     = 4'hf;
    // low byte of the control group
    localparam logic [7:0] CW_NOP      = 8'h00;
    localparam logic [7:0] CW_SLEEP    = 8'h03;
    localparam logic [7:0] CW_WDT      = 8'h04;
    localparam logic [7:0] CW_PUSH     = 8'h05;
    localparam logic [7:0] CW_POP      = 8'h06;
    localparam logic [7:0] CW_DAW      = 8'h07;
    localparam logic [5:0] CW_TABLE_READ_OP    = 6'h02;
    localparam logic [5:0] CW_TABLE_WRITE_OP    = 6'h03;
    localparam logic [6:0] CW_IRET     = 7'h08;
    localparam logic [6:0] CW_SRET     = 7'h09;
    localparam logic [7:0] CW_RESET    = 8'hff;

    typedef enum logic [4:0] {
        OP_NOP, OP_OTHER, OP_BIT_CLEAR, OP_BIT_SET, OP_BIT_TOGGLE,
        OP_TEST_SKIP_CLEAR, OP_TEST_SKIP_SET, OP_COND_JUMP, OP_REL_JUMP,
        OP_REL_CALL, OP_ABS_CALL, OP_ABS_JUMP, OP_WDT_CLEAR, OP_STANDBY,
        OP_STACK_POP, OP_STACK_PUSH, OP_SOFT_RESET, OP_IRQ_RETURN,
        OP_SUB_RETURN, OP_RETURN_CONST, OP_ADD_CONST, OP_CONST_MINUS,
        OP_AND_CONST, OP_OR_CONST, OP_XOR_CONST, OP_MUL_CONST,
        OP_LOAD_CONST, OP_BANK_LOAD, OP_PTR_LOAD, OP_TABLE_READ,
        OP_TABLE_WRITE, OP_DEC_ADJUST
    } cld_op_t;

    typedef struct packed {
        logic neg;
        logic overflow;
        logic zero;
        logic digit_carry;
        logic carry;
    } cld_flags_t;

    typedef struct packed {
        logic       valid;
        cld_op_t    op;
        logic [1:0] cycles;
        logic       pc_change;
        logic [7:0] konst;
        logic [2:0] bit_idx;
        logic       acc_bank;
        logic [7:0] file_addr;
        logic [10:0] rel_off;
        logic [19:0] abs_addr;
        logic       fast;
        logic [1:0] ptr_sel;
        logic [11:0] ptr_val;
        logic [1:0] tbl_mode;
        cld_flags_t flags_upd;
        logic       pin_read;
        logic       presc_clear;
        logic       wdt_restart;
        logic       standby;
        logic       sw_reset;
        logic       irq_reenable;
    } cld_dec_t;
endpackage : cld_pkg

// *** logic/cld_decoder.sv ***
// instruction decoder for bit, control, literal and table operations
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/100ps
//
// Contract
// - pc change or true test costs a second cycle run as nop
// - lone 1111 word is nop unless a first word takes it
// - bit write to timer zero counter clears prescaler if assigned
// - read-modify-write on a port uses pin levels, not latch
// - 1011 skip if bit clear, 1010 skip if set; 1 to 3 cycles
// - 1110 0ccc conditional jump, 8-bit signed offset, 2 cycles taken
// - 1101 relative jump or call by bit 11, two cycles, no flags
// - two-word absolute call and jump, address from both words
// - watchdog clear restarts watchdog, sets timeout and powerdown status
// - sleep enters standby, updates timeout and powerdown status
// - 0006 pops, 0005 pushes the return stack, no flags
// - 00ff performs a software reset of all state
// - interrupt return takes two cycles, reenables both irq enables
// - subroutine return with fast bit takes two cycles, no flags
// - return with constant loads working register, two cycles
// - add and constant-minus update all five flags, one cycle
// - and, or, xor constant update zero and negative only
// - multiply and load constant take one cycle, no flags
// - 0001 0000 kkkk loads the bank select register low nibble
// - two-word pointer load puts 12-bit constant in chosen pointer
// - table read 000 10mm, two cycles, pointer mode by mm
// - table write 000 11mm, same pointer modes as read
module cld_decoder #(
    parameter logic [7:0] TIMER0_ADDR = 8'hd6,
    parameter logic [7:0] PORT_LO     = 8'h80,
    parameter logic [7:0] PORT_HI     = 8'h84
) (
    input  wire logic                       ref_clk,
    input  wire logic                       rst_n,
    input  wire logic                       word_valid,
    input  wire logic [15:0]                word,
    output logic                            word_ready,
    input  wire cld_pkg::cld_flags_t        flags,
    input  wire logic                       test_bit,
    input  wire logic [cld_pkg::REG_AW-1:0] reg_addr,
    input  wire logic [7:0]                 reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic [7:0]                      reg_rdata,
    output cld_pkg::cld_dec_t               dec
);
    import cld_pkg::*;

    // the port window must be a real range
    if (PORT_LO > PORT_HI) begin : g_bad_port
        $error("port address range is empty");
    end

    typedef struct packed {
        cld_dec_t   dec;
        logic [7:0] ctrl;
        logic       tmout;
        logic       pwrdn;
        logic [3:0] bank;
        logic       flush;
        logic       skip;
        logic       second;
        cld_op_t    second_op;
        logic [8:0] first;
        logic       ready;
        logic [7:0] rdata;
    } cld_state_t;

    cld_state_t st;
    cld_state_t next_st;
    logic       acc;
    logic       plain;
    // reset image, shared by the pin reset and the software reset
    function automatic cld_state_t rst_state();
        cld_state_t s;
        s       = '0;
        s.ctrl  = CTRL_RST;
        s.tmout = TMOUT_RST;
        s.pwrdn = PWRDN_RST;
        s.ready = 1'b1;
        return s;
    endfunction : rst_state

    assign acc   = word_valid && st.ready;
    assign plain = acc && !st.flush && !st.skip && !st.second;

    // decode one accepted word per cycle
    always_comb begin
        cld_dec_t d;
        logic     sfr;
        logic     issue;
        d        = '0;
        sfr      = 1'b0;
        issue    = 1'b1;
        next_st          = st;
        next_st.dec      = '0;
        next_st.rdata    = 8'h00;
        next_st.ready    = 1'b1;
        // register port; unmapped status, last and bank bits read as zero, ctrl reads back all eight written bits
        if (reg_wr && reg_addr == REG_CTRL) begin
            next_st.ctrl = reg_wdata;
        end
        if (reg_rd) begin
            unique case (reg_addr)
                REG_CTRL: next_st.rdata = st.ctrl;
                REG_STAT: begin
                    next_st.rdata[STAT_TMOUT]  = st.tmout;
                    next_st.rdata[STAT_PWRDN]  = st.pwrdn;
                    next_st.rdata[STAT_FLUSH]  = st.flush;
                    next_st.rdata[STAT_SKIP]   = st.skip;
                    next_st.rdata[STAT_SECOND] = st.second;
                end
                REG_LAST: next_st.rdata = {3'h0, st.dec.op};
                REG_BANK: next_st.rdata = {4'h0, st.bank};
            endcase
        end
        if (acc) begin
            d.valid     = 1'b1;
            d.op        = OP_NOP;
            d.cycles    = CYC_ONE;
            d.konst     = word[7:0];
            d.file_addr = word[7:0];
            d.acc_bank  = word[8];
            d.bit_idx   = word[11:9];
            next_st.flush  = 1'b0;
            next_st.skip   = 1'b0;
            next_st.second = 1'b0;
            sfr = !word[8];
            if (st.flush || st.skip) begin
                d.op = OP_NOP; // discarded slot runs as nop
            end else if (st.second) begin
                // operand word of a two-word pair
                d.op     = st.second_op;
                d.cycles = CYC_TWO;
                if (st.second_op == OP_PTR_LOAD) begin
                    d.ptr_sel = st.first[5:4];
                    d.ptr_val = {st.first[3:0], word[7:0]};
                end else begin
                    d.abs_addr  = {word[11:0], st.first[7:0]};
                    d.fast      = (st.second_op == OP_ABS_CALL) &&
                                  st.first[8];
                    d.pc_change = 1'b1;
                end
            end else begin
                unique case (word[15:12])
                    NIB_BCLR: d.op = OP_BIT_CLEAR;
                    NIB_BSET: d.op = OP_BIT_SET;
                    NIB_BTGL: d.op = OP_BIT_TOGGLE;
                    NIB_TCLR: begin
                        d.op = OP_TEST_SKIP_CLEAR;
                        next_st.skip = !test_bit;
                    end
                    NIB_TSET: begin
                        d.op = OP_TEST_SKIP_SET;
                        next_st.skip = test_bit;
                    end
                    NIB_REL: begin
                        // bit 11 picks call over jump
                        d.op = word[11] ? OP_REL_CALL : OP_REL_JUMP;
                        d.rel_off   = word[10:0];
                        d.cycles    = CYC_TWO;
                        d.pc_change = 1'b1;
                    end
                    NIB_LONG: begin
                        if (!word[11]) begin
                            d.op      = OP_COND_JUMP;
                            d.rel_off = {{3{word[7]}}, word[7:0]};
                            unique case (word[10:9])
                                2'h0: d.pc_change = flags.zero;
                                2'h1: d.pc_change = flags.carry;
                                2'h2: d.pc_change = flags.overflow;
                                2'h3: d.pc_change = flags.neg;
                            endcase
                            d.pc_change = d.pc_change ^ word[8];
                            if (d.pc_change) d.cycles = CYC_TWO;
                        end else if (word[11:9] == SUB_CALL ||
                                     word[11:8] == SUB_JUMP ||
                                     (word[11:8] == SUB_PTR &&
                                      word[7:6] == PTR_ZERO)) begin
                            // hold the first word for its operand
                            issue = 1'b0;
                            next_st.second = 1'b1;
                            next_st.first  = word[8:0];
                            if (word[11:8] == SUB_JUMP)
                                next_st.second_op = OP_ABS_JUMP;
                            else if (word[11:8] == SUB_PTR)
                                next_st.second_op = OP_PTR_LOAD;
                            else
                                next_st.second_op = OP_ABS_CALL;
                        end else begin
                            d.op = OP_OTHER;
                        end
                    end
                    NIB_SECOND: d.op = OP_NOP;
                    NIB_MISC: begin
                        unique case (word[11:8])
                            LIT_ADD: begin
                                d.op = OP_ADD_CONST;
                                d.flags_upd = 5'h1f;
                            end
                            LIT_SUB: begin
                                d.op = OP_CONST_MINUS;
                                d.flags_upd = 5'h1f;
                            end
                            LIT_AND, LIT_OR, LIT_XOR: begin
                                d.op = (word[11:8] == LIT_AND) ?
                                       OP_AND_CONST :
                                       (word[11:8] == LIT_OR) ?
                                       OP_OR_CONST : OP_XOR_CONST;
                                d.flags_upd.zero = 1'b1;
                                d.flags_upd.neg  = 1'b1;
                            end
                            LIT_MUL:  d.op = OP_MUL_CONST;
                            LIT_LOAD: d.op = OP_LOAD_CONST;
                            LIT_RET: begin
                                d.op = OP_RETURN_CONST;
                                d.cycles    = CYC_TWO;
                                d.pc_change = 1'b1;
                            end
                            LIT_BANK: begin
                                if (word[7:4] == 4'h0) begin
                                    d.op = OP_BANK_LOAD;
                                    next_st.bank = word[3:0];
                                end else begin
                                    d.op = OP_OTHER;
                                end
                            end
                            LIT_CTRL: begin
                                d.op = OP_OTHER;
                                unique case (word[7:0])
                                    CW_NOP:  d.op = OP_NOP;
                                    CW_SLEEP: begin
                                        d.op = OP_STANDBY;
                                        d.standby = 1'b1;
                                        next_st.tmout = 1'b1;
                                        next_st.pwrdn = 1'b0;
                                    end
                                    CW_WDT: begin
                                        d.op = OP_WDT_CLEAR;
                                        d.wdt_restart = 1'b1;
                                        next_st.tmout = 1'b1;
                                        next_st.pwrdn = 1'b1;
                                    end
                                    CW_PUSH: d.op = OP_STACK_PUSH;
                                    CW_POP:  d.op = OP_STACK_POP;
                                    CW_DAW: begin
                                        d.op = OP_DEC_ADJUST;
                                        d.flags_upd.carry = 1'b1;
                                    end
                                    CW_RESET: begin
                                        d.op = OP_SOFT_RESET;
                                        d.sw_reset = 1'b1;
                                    end
                                    default: begin
                                        if (word[7:2] == CW_TABLE_READ_OP ||
                                            word[7:2] == CW_TABLE_WRITE_OP) begin
                                            d.op = word[2] ?
                                                   OP_TABLE_WRITE :
                                                   OP_TABLE_READ;
                                            d.tbl_mode = word[1:0];
                                            d.cycles   = CYC_TWO;
                                            next_st.ready = 1'b0;
                                        end else if (word[7:1] == CW_IRET) begin
                                            d.op = OP_IRQ_RETURN;
                                            d.irq_reenable = 1'b1;
                                            d.fast      = word[0];
                                            d.cycles    = CYC_TWO;
                                            d.pc_change = 1'b1;
                                        end else if (word[7:1] == CW_SRET) begin
                                            d.op = OP_SUB_RETURN;
                                            d.fast      = word[0];
                                            d.cycles    = CYC_TWO;
                                            d.pc_change = 1'b1;
                                        end
                                    end
                                endcase
                            end
                            default: d.op = OP_OTHER;
                        endcase
                    end
                    default: d.op = OP_OTHER;
                endcase
                // bit writes on special registers
                if (d.op == OP_BIT_CLEAR || d.op == OP_BIT_SET ||
                    d.op == OP_BIT_TOGGLE) begin
                    d.pin_read = sfr && word[7:0] >= PORT_LO &&
                                 word[7:0] <= PORT_HI;
                    d.presc_clear = sfr && word[7:0] == TIMER0_ADDR &&
                                    st.ctrl[CTRL_PRESC];
                end
            end
            next_st.flush = d.pc_change; // prefetched word dies
            if (issue) begin
                next_st.dec = d;
            end
        end
        // software reset replaces every piece of state
        if (next_st.dec.sw_reset) begin
            next_st     = rst_state();
            next_st.dec = d;
        end
    end

    // one register stage holds all state
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st <= rst_state();
        end else begin
            st <= next_st;
        end
    end

    assign word_ready = st.ready;
    assign reg_rdata  = st.rdata;
    assign dec        = st.dec;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_rel_jump;
        plain && word[15:12] == NIB_REL |=> dec.cycles == CYC_TWO &&
            dec.pc_change ##1 (!word_valid || dec.op == OP_NOP);
    endproperty
    a_rel_jump: assert property (p_rel_jump)
        else $error("relative jump not two cycles with flushed slot");

    property p_lone_second;
        plain && word[15:12] == NIB_SECOND |=> dec.valid &&
            dec.op == OP_NOP && !dec.pc_change;
    endproperty
    a_lone_second: assert property (p_lone_second)
        else $error("lone operand word did not decode as nop");

    property p_presc;
        plain && word[15:12] == NIB_BSET && !word[8] &&
            word[7:0] == TIMER0_ADDR && st.ctrl[CTRL_PRESC]
            |=> dec.presc_clear && dec.op == OP_BIT_SET;
    endproperty
    a_presc: assert property (p_presc)
        else $error("prescaler not cleared on timer write");

    property p_skip;
        plain && word[15:12] == NIB_TCLR && !test_bit
            |=> st.skip ##0 (!acc or (acc ##1 dec.op == OP_NOP));
    endproperty
    a_skip: assert property (p_skip)
        else $error("clear-bit test did not skip next word");

    property p_cond_zero;
        plain && word[15:8] == 8'he0 && flags.zero
            |=> dec.pc_change && dec.cycles == CYC_TWO && st.flush;
    endproperty
    a_cond_zero: assert property (p_cond_zero)
        else $error("zero branch not taken");

    property p_wdt;
        plain && word == {8'h00, CW_WDT}
            |=> st.tmout && st.pwrdn && dec.wdt_restart;
    endproperty
    a_wdt: assert property (p_wdt)
        else $error("watchdog clear status wrong");

    property p_sleep;
        plain && word == {8'h00, CW_SLEEP}
            |=> st.tmout && !st.pwrdn && dec.standby;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep status wrong");

    property p_soft_reset;
        plain && word == {8'h00, CW_RESET} && !reg_wr
            |=> dec.sw_reset && st.bank == 4'h0 && st.ctrl == CTRL_RST;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("software reset left state behind");

    property p_bank;
        plain && word[15:4] == 12'h010 |=> st.bank == $past(word[3:0]);
    endproperty
    a_bank: assert property (p_bank)
        else $error("bank select not loaded");

    property p_table;
        plain && word[15:3] == 13'h0001
            |=> !word_ready && dec.cycles == CYC_TWO ##1 word_ready;
    endproperty
    a_table: assert property (p_table)
        else $error("table op did not hold the fetch one cycle");
endmodule : cld_decoder
